// *** inc/fisb_pkg.sv ***
// Constants for the fault and interrupt status register bank.
// Assumes an 8-bit register port and one 200 MHz clock domain.
package fisb_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int SRC_W = 20;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_LTCH_EVT = 8'h3B;
  localparam logic [7:0] ADDR_CLK_STS = 8'h3C;
  localparam logic [7:0] ADDR_CH_SUM = 8'h3D;
  localparam logic [7:0] ADDR_OUT1 = 8'h40;
  localparam logic [7:0] ADDR_OUT2 = 8'h41;
  localparam logic [7:0] ADDR_HS = 8'h42;
  localparam logic [7:0] ADDR_IRQ_STS = 8'h44;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h45;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_MASK = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_GPA_UP = 7;
  localparam int BIT_GPA_LOW = 6;
  localparam int BIT_VAD_UP = 5;
  localparam int BIT_VAD_DN = 4;
  localparam int BIT_CLK_ERR = 7;
  localparam int BIT_PLL_LOCK = 6;
  localparam int BIT_IN1 = 7;
  localparam int BIT_IN2 = 6;
  localparam int BIT_OUT1 = 5;
  localparam int BIT_OUT2 = 4;
  localparam int BIT_SC_P = 7;
  localparam int BIT_SC_M = 6;
  localparam int BIT_VG_P = 5;
  localparam int BIT_VG_M = 4;
  localparam int BIT_ANALOG_REGULATOR = 0;
  localparam int BIT_HS_INS = 3;
  localparam int BIT_HS_REM = 2;
  localparam int BIT_HS_HOOK = 1;
  localparam int BIT_IRQ_CLK = 0;

  // ----------------------------------------------------------------
  // Source vector indices
  // ----------------------------------------------------------------
  localparam int SRC_GPA_UP = 0;
  localparam int SRC_GPA_LOW = 1;
  localparam int SRC_VAD_UP = 2;
  localparam int SRC_VAD_DN = 3;
  localparam int SRC_CLK_ERR = 4;
  localparam int SRC_PLL_LOCK = 5;
  localparam int SRC_IN1 = 6;
  localparam int SRC_IN2 = 7;
  localparam int SRC_O1_SC_P = 8;
  localparam int SRC_O1_SC_M = 9;
  localparam int SRC_O1_VG_P = 10;
  localparam int SRC_O1_VG_M = 11;
  localparam int SRC_O2_SC_P = 12;
  localparam int SRC_O2_SC_M = 13;
  localparam int SRC_O2_VG_P = 14;
  localparam int SRC_O2_VG_M = 15;
  localparam int SRC_ANALOG_REGULATOR = 16;
  localparam int SRC_HS_INS = 17;
  localparam int SRC_HS_REM = 18;
  localparam int SRC_HS_HOOK = 19;

endpackage

// *** hdl/fisb_status_bank.sv ***
// Fault and interrupt status register bank of an audio codec.
// Assumes detector levels arrive asynchronously from analog blocks
// and a simple strobe register port on the same clock as this bank.

// Function
// - Latch bit 7 on upper threshold crossing
// - Latch bit 6 on lower threshold crossing
// - Latch bit 5 on voice power-up detect
// - Latch bit 4 on voice power-down detect
// - Reserved bits read zero, writes ignored
// - Clock status bit 7 follows clock error
// - Clock status bit 6 follows PLL lock
// - Summary bits 7..4 flag channel faults
// - Output one bits 7,6 pin shorts
// - Output one bits 5,4 virtual ground
// - Output two bits 7,6 pin shorts
// - Output two bits 5,4 virtual ground
// - Output two bit 0 regulator short
// - Headset bit 3 shows insertion
// - Headset bit 2 shows removal
// - Hook button flag placed at bit 1
module fisb_status_bank (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Register port
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  // Monitor and voice detector levels
  input wire logic gpa_up_in,
  input wire logic gpa_low_in,
  input wire logic vad_up_in,
  input wire logic vad_down_in,
  // Clocking levels
  input wire logic clk_err_in,
  input wire logic pll_lock_in,
  // Input channel fault levels
  input wire logic in1_fault_in,
  input wire logic in2_fault_in,
  // Output one fault levels
  input wire logic out1_sc_p_in,
  input wire logic out1_sc_m_in,
  input wire logic out1_vg_p_in,
  input wire logic out1_vg_m_in,
  // Output two fault levels
  input wire logic out2_sc_p_in,
  input wire logic out2_sc_m_in,
  input wire logic out2_vg_p_in,
  input wire logic out2_vg_m_in,
  input wire logic analog_regulator_short_in,
  // Headset levels
  input wire logic hs_insert_in,
  input wire logic hs_remove_in,
  input wire logic hs_hook_in,
  // Interrupt
  output logic irq_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [fisb_pkg::SRC_W-1:0] sync1;
    logic [fisb_pkg::SRC_W-1:0] sync2;
    logic [fisb_pkg::SRC_W-1:0] sync3;
    logic [fisb_pkg::SRC_W-1:0] filt;
    logic [7:0] ltch_evt;
    logic [7:0] irq_sts;
    logic [7:0] irq_mask;
    logic [7:0] rdata;
  } fisb_state_s;

  fisb_state_s st_reg;
  fisb_state_s st_next;
  logic [fisb_pkg::SRC_W-1:0] src_raw;
  logic [7:0] clk_live;
  logic [7:0] ch_live;
  logic [7:0] out1_live;
  logic [7:0] out2_live;
  logic [7:0] hs_live;
  logic rd_ltch;

  // ----------------------------------------------------------------
  // Source collection
  // ----------------------------------------------------------------
  assign src_raw = {hs_hook_in, hs_remove_in, hs_insert_in, analog_regulator_short_in,
                    out2_vg_m_in, out2_vg_p_in, out2_sc_m_in, out2_sc_p_in,
                    out1_vg_m_in, out1_vg_p_in, out1_sc_m_in, out1_sc_p_in,
                    in2_fault_in, in1_fault_in, pll_lock_in, clk_err_in,
                    vad_down_in, vad_up_in, gpa_low_in, gpa_up_in};

  assign rd_ltch = rd_in && (addr_in == fisb_pkg::ADDR_LTCH_EVT);

  // ----------------------------------------------------------------
  // Live register images
  // ----------------------------------------------------------------
  // Unlisted bits stay at zero, so reserved fields always read zero
  always_comb
  begin
    clk_live = fisb_pkg::RST_STATUS;
    clk_live[fisb_pkg::BIT_CLK_ERR] = st_reg.filt[fisb_pkg::SRC_CLK_ERR];
    clk_live[fisb_pkg::BIT_PLL_LOCK] = st_reg.filt[fisb_pkg::SRC_PLL_LOCK];
    out1_live = fisb_pkg::RST_STATUS;
    out1_live[fisb_pkg::BIT_SC_P] = st_reg.filt[fisb_pkg::SRC_O1_SC_P];
    out1_live[fisb_pkg::BIT_SC_M] = st_reg.filt[fisb_pkg::SRC_O1_SC_M];
    out1_live[fisb_pkg::BIT_VG_P] = st_reg.filt[fisb_pkg::SRC_O1_VG_P];
    out1_live[fisb_pkg::BIT_VG_M] = st_reg.filt[fisb_pkg::SRC_O1_VG_M];
    out2_live = fisb_pkg::RST_STATUS;
    out2_live[fisb_pkg::BIT_SC_P] = st_reg.filt[fisb_pkg::SRC_O2_SC_P];
    out2_live[fisb_pkg::BIT_SC_M] = st_reg.filt[fisb_pkg::SRC_O2_SC_M];
    out2_live[fisb_pkg::BIT_VG_P] = st_reg.filt[fisb_pkg::SRC_O2_VG_P];
    out2_live[fisb_pkg::BIT_VG_M] = st_reg.filt[fisb_pkg::SRC_O2_VG_M];
    out2_live[fisb_pkg::BIT_ANALOG_REGULATOR] = st_reg.filt[fisb_pkg::SRC_ANALOG_REGULATOR];
    // Output summaries are the OR of that channel's whole image, so output two also takes the regulator short
    ch_live = fisb_pkg::RST_STATUS;
    ch_live[fisb_pkg::BIT_IN1] = st_reg.filt[fisb_pkg::SRC_IN1];
    ch_live[fisb_pkg::BIT_IN2] = st_reg.filt[fisb_pkg::SRC_IN2];
    ch_live[fisb_pkg::BIT_OUT1] = |out1_live;
    ch_live[fisb_pkg::BIT_OUT2] = |out2_live;
    hs_live = fisb_pkg::RST_STATUS;
    hs_live[fisb_pkg::BIT_HS_INS] = st_reg.filt[fisb_pkg::SRC_HS_INS];
    hs_live[fisb_pkg::BIT_HS_REM] = st_reg.filt[fisb_pkg::SRC_HS_REM];
    // Printed position clashes with removal; bit 1 matches the latched copy
    hs_live[fisb_pkg::BIT_HS_HOOK] = st_reg.filt[fisb_pkg::SRC_HS_HOOK];
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [fisb_pkg::SRC_W-1:0] rise;
    logic [7:0] ltch_set;
    logic [7:0] irq_set;
    logic [7:0] irq_clr;
    rise = '0;
    ltch_set = fisb_pkg::RST_STATUS;
    irq_set = fisb_pkg::RST_STATUS;
    irq_clr = fisb_pkg::RST_STATUS;
    st_next = st_reg;
    // Three stages; a level is taken once stages two and three agree
    st_next.sync1 = src_raw;
    st_next.sync2 = st_reg.sync1;
    st_next.sync3 = st_reg.sync2;
    for (int i = 0; i < fisb_pkg::SRC_W; i++)
    begin
      if (st_reg.sync2[i] == st_reg.sync3[i])
      begin
        st_next.filt[i] = st_reg.sync3[i];
      end
    end
    rise = st_next.filt & ~st_reg.filt;
    ltch_set[fisb_pkg::BIT_GPA_UP] = rise[fisb_pkg::SRC_GPA_UP];
    ltch_set[fisb_pkg::BIT_GPA_LOW] = rise[fisb_pkg::SRC_GPA_LOW];
    ltch_set[fisb_pkg::BIT_VAD_UP] = rise[fisb_pkg::SRC_VAD_UP];
    ltch_set[fisb_pkg::BIT_VAD_DN] = rise[fisb_pkg::SRC_VAD_DN];
    // A new event in the reading cycle survives the clear
    if (rd_ltch)
    begin
      st_next.ltch_evt = ltch_set;
    end
    else
    begin
      st_next.ltch_evt = st_reg.ltch_evt | ltch_set;
    end
    // Interrupt events share the latched layout in the upper nibble
    irq_set = ltch_set;
    irq_set[fisb_pkg::BIT_HS_INS] = rise[fisb_pkg::SRC_HS_INS];
    irq_set[fisb_pkg::BIT_HS_REM] = rise[fisb_pkg::SRC_HS_REM];
    irq_set[fisb_pkg::BIT_HS_HOOK] = rise[fisb_pkg::SRC_HS_HOOK];
    irq_set[fisb_pkg::BIT_IRQ_CLK] = rise[fisb_pkg::SRC_CLK_ERR];
    if (wr_in && (addr_in == fisb_pkg::ADDR_IRQ_STS))
    begin
      irq_clr = wdata_in;
    end
    st_next.irq_sts = (st_reg.irq_sts & ~irq_clr) | irq_set;
    if (wr_in && (addr_in == fisb_pkg::ADDR_IRQ_MASK))
    begin
      st_next.irq_mask = wdata_in;
    end
    // Writes to status offsets are dropped; nothing there is writable
    st_next.rdata = fisb_pkg::RST_STATUS;
    if (rd_in)
    begin
      if (addr_in == fisb_pkg::ADDR_LTCH_EVT)
      begin
        st_next.rdata = st_reg.ltch_evt;
      end
      else if (addr_in == fisb_pkg::ADDR_CLK_STS)
      begin
        st_next.rdata = clk_live;
      end
      else if (addr_in == fisb_pkg::ADDR_CH_SUM)
      begin
        st_next.rdata = ch_live;
      end
      else if (addr_in == fisb_pkg::ADDR_OUT1)
      begin
        st_next.rdata = out1_live;
      end
      else if (addr_in == fisb_pkg::ADDR_OUT2)
      begin
        st_next.rdata = out2_live;
      end
      else if (addr_in == fisb_pkg::ADDR_HS)
      begin
        st_next.rdata = hs_live;
      end
      else if (addr_in == fisb_pkg::ADDR_IRQ_STS)
      begin
        st_next.rdata = st_reg.irq_sts;
      end
      else if (addr_in == fisb_pkg::ADDR_IRQ_MASK)
      begin
        st_next.rdata = st_reg.irq_mask;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      st_reg.sync1 <= '0;
      st_reg.sync2 <= '0;
      st_reg.sync3 <= '0;
      st_reg.filt <= '0;
      st_reg.ltch_evt <= fisb_pkg::RST_STATUS;
      st_reg.irq_sts <= fisb_pkg::RST_STATUS;
      st_reg.irq_mask <= fisb_pkg::RST_MASK;
      st_reg.rdata <= fisb_pkg::RST_STATUS;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign rdata_out = st_reg.rdata;
  assign irq_out = |(st_reg.irq_sts & st_reg.irq_mask);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  logic [fisb_pkg::SRC_W-1:0] take_hi;
  assign take_hi = st_reg.sync2 & st_reg.sync3 & ~st_reg.filt;

  property p_gpa_up;
    take_hi[fisb_pkg::SRC_GPA_UP] |=> st_reg.ltch_evt[fisb_pkg::BIT_GPA_UP];
  endproperty
  a_gpa_up: assert property (p_gpa_up)
    else $error("upper threshold event not latched");

  property p_gpa_low;
    $rose(st_reg.filt[fisb_pkg::SRC_GPA_LOW])
      |-> st_reg.ltch_evt[fisb_pkg::BIT_GPA_LOW];
  endproperty
  a_gpa_low: assert property (p_gpa_low)
    else $error("lower threshold event not latched");

  property p_vad_up;
    take_hi[fisb_pkg::SRC_VAD_UP]
      |=> st_reg.ltch_evt[fisb_pkg::BIT_VAD_UP];
  endproperty
  a_vad_up: assert property (p_vad_up)
    else $error("voice power-up event not latched");

  property p_vad_dn;
    take_hi[fisb_pkg::SRC_VAD_DN] ##1 !rd_ltch
      |=> st_reg.ltch_evt[fisb_pkg::BIT_VAD_DN];
  endproperty
  a_vad_dn: assert property (p_vad_dn)
    else $error("voice power-down event lost");

  property p_ltch_resv;
    rd_ltch |=> rdata_out[3:0] == 4'h0;
  endproperty
  a_ltch_resv: assert property (p_ltch_resv)
    else $error("latched reserved bits not zero");

  property p_clk_read;
    rd_in && addr_in == fisb_pkg::ADDR_CLK_STS
      |=> rdata_out == {$past(st_reg.filt[fisb_pkg::SRC_CLK_ERR]),
                        $past(st_reg.filt[fisb_pkg::SRC_PLL_LOCK]), 6'h00};
  endproperty
  a_clk_read: assert property (p_clk_read)
    else $error("clock status readback wrong");

  property p_out1_read;
    rd_in && addr_in == fisb_pkg::ADDR_OUT1
      |=> rdata_out[3:0] == 4'h0 && rdata_out[7:4] == $past({
          st_reg.filt[fisb_pkg::SRC_O1_SC_P], st_reg.filt[fisb_pkg::SRC_O1_SC_M],
          st_reg.filt[fisb_pkg::SRC_O1_VG_P], st_reg.filt[fisb_pkg::SRC_O1_VG_M]});
  endproperty
  a_out1_read: assert property (p_out1_read)
    else $error("output one readback wrong");

  property p_out2_read;
    rd_in && addr_in == fisb_pkg::ADDR_OUT2
      |=> rdata_out[3:1] == 3'h0
        && rdata_out[0] == $past(st_reg.filt[fisb_pkg::SRC_ANALOG_REGULATOR]);
  endproperty
  a_out2_read: assert property (p_out2_read)
    else $error("output two low bits wrong");

  property p_hook_read;
    rd_in && addr_in == fisb_pkg::ADDR_HS
      |=> rdata_out[fisb_pkg::BIT_HS_HOOK] == $past(st_reg.filt[fisb_pkg::SRC_HS_HOOK])
        && rdata_out[7:4] == 4'h0;
  endproperty
  a_hook_read: assert property (p_hook_read)
    else $error("hook flag readback wrong");

  property p_sum_read;
    rd_in && addr_in == fisb_pkg::ADDR_CH_SUM
      |=> rdata_out[3:0] == 4'h0 && rdata_out[7:6] == $past({
          st_reg.filt[fisb_pkg::SRC_IN1], st_reg.filt[fisb_pkg::SRC_IN2]});
  endproperty
  a_sum_read: assert property (p_sum_read)
    else $error("channel summary readback wrong");

  property p_out2_pins;
    rd_in && addr_in == fisb_pkg::ADDR_OUT2
      |=> rdata_out[7:4] == $past({
          st_reg.filt[fisb_pkg::SRC_O2_SC_P], st_reg.filt[fisb_pkg::SRC_O2_SC_M],
          st_reg.filt[fisb_pkg::SRC_O2_VG_P], st_reg.filt[fisb_pkg::SRC_O2_VG_M]});
  endproperty
  a_out2_pins: assert property (p_out2_pins)
    else $error("output two pin faults readback wrong");

  property p_hs_insert;
    rd_in && addr_in == fisb_pkg::ADDR_HS
      |=> rdata_out[fisb_pkg::BIT_HS_INS] == $past(st_reg.filt[fisb_pkg::SRC_HS_INS]);
  endproperty
  a_hs_insert: assert property (p_hs_insert)
    else $error("headset insert readback wrong");

  property p_hs_remove;
    rd_in && addr_in == fisb_pkg::ADDR_HS
      |=> rdata_out[fisb_pkg::BIT_HS_REM] == $past(st_reg.filt[fisb_pkg::SRC_HS_REM])
        && rdata_out[0] == 1'b0;
  endproperty
  a_hs_remove: assert property (p_hs_remove)
    else $error("headset removal readback wrong");

  property p_ltch_hold;
    st_reg.ltch_evt[fisb_pkg::BIT_GPA_UP] && !rd_ltch
      |=> st_reg.ltch_evt[fisb_pkg::BIT_GPA_UP];
  endproperty
  a_ltch_hold: assert property (p_ltch_hold)
    else $error("latched flag dropped without read");

  property p_ltch_clear;
    rd_ltch && !(|take_hi[3:0]) |=> st_reg.ltch_evt == 8'h00;
  endproperty
  a_ltch_clear: assert property (p_ltch_clear)
    else $error("latched flags not cleared by read");

  property p_live_follow;
    st_reg.sync2 == st_reg.sync3 |=> st_reg.filt == $past(st_reg.sync3);
  endproperty
  a_live_follow: assert property (p_live_follow)
    else $error("live flag not following source");

  c_ltch_read: cover property (st_reg.ltch_evt != 8'h00 ##1 rd_ltch);
  c_irq: cover property ($rose(irq_out));
  c_set_on_read: cover property (rd_ltch && (|take_hi[3:0]));

endmodule // fisb_status_bank

// *** verification/fisb_host_model.sv ***
// Host model: the strobe bus master that reads the status bank.
// Assumes one clock shared with the bank and read data one cycle late.
module fisb_host_model (
  // Clock
  input wire logic clk_in,
  // Register port
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out,
  output logic wr_out,
  output logic rd_out,
  input wire logic [7:0] rdata_in
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    addr_out = 8'h00;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end

  // ------------
  // Bus cycles
  // ------------
  // Released lines show the inverse so stale values never pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
    addr_out <= ~a;
    wdata_out <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    addr_out <= ~a;
    // Data stand only in the cycle after the taking edge
    @(negedge clk_in);
    d = rdata_in;
  endtask
endmodule // fisb_host_model

// *** verification/tb_top.sv ***
// Self-checking bench for the status bank: a row table, then edge cases.
// Assumes the host model drives the register port on the bench clock.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct {
    int idx;
    logic [7:0] addr;
    logic [7:0] exp;
  } fisb_row_s;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic irq;
  logic [19:0] src = 20'h00000;
  int err_total = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [7:0] chk_addr [9] = '{8'h3B, 8'h3C, 8'h3D, 8'h40, 8'h41, 8'h42, 8'h3E, 8'h44, 8'h45};
  fisb_row_s rows [22];

  always #2.5 clk = ~clk;

  // ------------
  // Instances
  // ------------
  fisb_status_bank fisb_status_bank_i (
    .clk_in(clk), .rst_n_in(rst_n), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .irq_out(irq),
    .gpa_up_in(src[fisb_pkg::SRC_GPA_UP]), .gpa_low_in(src[fisb_pkg::SRC_GPA_LOW]),
    .vad_up_in(src[fisb_pkg::SRC_VAD_UP]), .vad_down_in(src[fisb_pkg::SRC_VAD_DN]),
    .clk_err_in(src[fisb_pkg::SRC_CLK_ERR]), .pll_lock_in(src[fisb_pkg::SRC_PLL_LOCK]),
    .in1_fault_in(src[fisb_pkg::SRC_IN1]), .in2_fault_in(src[fisb_pkg::SRC_IN2]),
    .out1_sc_p_in(src[fisb_pkg::SRC_O1_SC_P]), .out1_sc_m_in(src[fisb_pkg::SRC_O1_SC_M]),
    .out1_vg_p_in(src[fisb_pkg::SRC_O1_VG_P]), .out1_vg_m_in(src[fisb_pkg::SRC_O1_VG_M]),
    .out2_sc_p_in(src[fisb_pkg::SRC_O2_SC_P]), .out2_sc_m_in(src[fisb_pkg::SRC_O2_SC_M]),
    .out2_vg_p_in(src[fisb_pkg::SRC_O2_VG_P]), .out2_vg_m_in(src[fisb_pkg::SRC_O2_VG_M]),
    .analog_regulator_short_in(src[fisb_pkg::SRC_ANALOG_REGULATOR]), .hs_insert_in(src[fisb_pkg::SRC_HS_INS]),
    .hs_remove_in(src[fisb_pkg::SRC_HS_REM]), .hs_hook_in(src[fisb_pkg::SRC_HS_HOOK])
  );

  fisb_host_model fisb_host_model_i (
    .clk_in(clk), .addr_out(addr), .wdata_out(wdata), .wr_out(wr), .rd_out(rd),
    .rdata_in(rdata)
  );

  // ------------
  // Checking and closing
  // ------------
  task automatic check8(input string what, input logic [7:0] e, input logic [7:0] got);
    tests_run++;
    if (got !== e)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, e, got);
    end
  endtask

  task automatic check1(input string what, input logic e, input logic got);
    tests_run++;
    if (got !== e)
    begin
      err_total++;
      $display("wrong value %s expected %b seen %b", what, e, got);
    end
  endtask

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] got;
    fisb_host_model_i.rd(a, got);
    check8($sformatf("reg %h", a), e, got);
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    fisb_host_model_i.wr(a, d);
  endtask

  // Sources pass a three-stage filter before they show
  task automatic drive_src(input logic [19:0] v);
    @(posedge clk);
    src <= v;
    repeat (6) @(posedge clk);
  endtask

  // Bounds a hang; the whole run needs under 2000 cycles
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      err_total = err_total + 1;
      finish_test();
    end
  end

  // ------------
  // Sequence
  // ------------
  initial
  begin
    rows = '{
      '{fisb_pkg::SRC_GPA_UP, 8'h3B, 8'h80}, '{fisb_pkg::SRC_GPA_LOW, 8'h3B, 8'h40},
      '{fisb_pkg::SRC_VAD_UP, 8'h3B, 8'h20}, '{fisb_pkg::SRC_VAD_DN, 8'h3B, 8'h10},
      '{fisb_pkg::SRC_CLK_ERR, 8'h3C, 8'h80}, '{fisb_pkg::SRC_PLL_LOCK, 8'h3C, 8'h40},
      '{fisb_pkg::SRC_IN1, 8'h3D, 8'h80}, '{fisb_pkg::SRC_IN2, 8'h3D, 8'h40},
      '{fisb_pkg::SRC_O1_SC_M, 8'h3D, 8'h20}, '{fisb_pkg::SRC_ANALOG_REGULATOR, 8'h3D, 8'h10},
      '{fisb_pkg::SRC_O1_SC_P, 8'h40, 8'h80}, '{fisb_pkg::SRC_O1_SC_M, 8'h40, 8'h40},
      '{fisb_pkg::SRC_O1_VG_P, 8'h40, 8'h20}, '{fisb_pkg::SRC_O1_VG_M, 8'h40, 8'h10},
      '{fisb_pkg::SRC_O2_SC_P, 8'h41, 8'h80}, '{fisb_pkg::SRC_O2_SC_M, 8'h41, 8'h40},
      '{fisb_pkg::SRC_O2_VG_P, 8'h41, 8'h20}, '{fisb_pkg::SRC_O2_VG_M, 8'h41, 8'h10},
      '{fisb_pkg::SRC_ANALOG_REGULATOR, 8'h41, 8'h01}, '{fisb_pkg::SRC_HS_INS, 8'h42, 8'h08},
      '{fisb_pkg::SRC_HS_REM, 8'h42, 8'h04}, '{fisb_pkg::SRC_HS_HOOK, 8'h42, 8'h02}};
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    foreach (chk_addr[i])
      rd_chk(chk_addr[i], 8'h00);
    check1("irq", 1'b0, irq);
    foreach (rows[i])
    begin
      drive_src(20'h00001 << rows[i].idx);
      rd_chk(rows[i].addr, rows[i].exp);
      drive_src(20'h00000);
    end
    // Every event kind has left its mark in the interrupt status
    rd_chk(8'h44, 8'hFF);
    // Latched flag survives a short pulse and other reads
    drive_src(20'h00001 << fisb_pkg::SRC_GPA_UP);
    drive_src(20'h00000);
    rd_chk(8'h3C, 8'h00);
    rd_chk(8'h3B, 8'h80);
    @(negedge clk);
    check8("idle rdata", 8'h00, rdata);
    rd_chk(8'h3B, 8'h00);
    // Live flag survives reads, then follows its source down
    drive_src(20'h00001 << fisb_pkg::SRC_CLK_ERR);
    rd_chk(8'h3C, 8'h80);
    rd_chk(8'h3C, 8'h80);
    drive_src(20'h00000);
    rd_chk(8'h3C, 8'h00);
    // Writes to status and unmapped places change nothing
    for (int i = 0; i < 7; i++)
    begin
      wr_reg(chk_addr[i], 8'hFF);
      rd_chk(chk_addr[i], 8'h00);
    end
    // Interrupt raised, read, cleared, then masked
    wr_reg(8'h44, 8'hFF);
    wr_reg(8'h45, 8'h80);
    rd_chk(8'h45, 8'h80);
    drive_src(20'h00001 << fisb_pkg::SRC_GPA_UP);
    check1("irq", 1'b1, irq);
    rd_chk(8'h44, 8'h80);
    wr_reg(8'h44, 8'h80);
    @(negedge clk);
    check1("irq", 1'b0, irq);
    rd_chk(8'h44, 8'h00);
    drive_src(20'h00001 << fisb_pkg::SRC_GPA_LOW);
    check1("irq", 1'b0, irq);
    rd_chk(8'h44, 8'h40);
    rd_chk(8'h3B, 8'hC0);
    // Reset in mid-run with flags and mask set
    wr_reg(8'h45, 8'hFF);
    drive_src(20'h00001 << fisb_pkg::SRC_VAD_UP);
    check1("irq", 1'b1, irq);
    @(posedge clk);
    src <= 20'h00000;
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check1("irq", 1'b0, irq);
    foreach (chk_addr[i])
      rd_chk(chk_addr[i], 8'h00);
    finish_test();
  end
endmodule // tb_top
